/* pasi_pkg.sv */
// Shared constants for the programmable array system interface
package pasi_pkg;
  // AHB transfer encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'h0;
  // Array address space: page select and region within page
  localparam int ADDR_W = 17;
  localparam int PAGE_BIT = 16;
  localparam logic PAGE_WORK = 1'h0;
  localparam logic PAGE_CFG = 1'h1;
  localparam logic [15:0] WORK16_BASE = 16'h1000;
  // System interface registers inside configuration page
  localparam logic [15:0] SYS_BASE = 16'hff00;
  localparam logic [7:0] OFS_ACC_WAIT = 8'h00;
  localparam logic [7:0] OFS_BANK_GLOB = 8'h01;
  localparam logic [7:0] OFS_MDCLK = 8'h02;
  localparam logic [7:0] OFS_MBCLK = 8'h03;
  localparam logic [7:0] OFS_QDCLK0 = 8'h10;
  localparam logic [7:0] OFS_QBCLK0 = 8'h14;
  localparam int NUM_QUAD = 4;
  localparam int NUM_DCLK = 8;
  // access_wait_config fields: 2 bits each
  localparam int WT_WORK_RD = 0;
  localparam int WT_WORK_WR = 2;
  localparam int WT_CFG_RD = 4;
  localparam int WT_CFG_WR = 6;
  // bank_global_control fields
  localparam int BC_ROUTE_EN = 0;
  localparam int BC_NO_CLR_RD = 1;
  localparam int BC_RAM_TEST = 2;
  localparam int BC_GLOB_WR = 3;
  // quadrant_bus_clock_gate fields
  localparam int QB_BUS_EN = 0;
  localparam int QB_CHAN_GWR = 1;
  localparam int QB_ROUTE_DIS = 2;
  // Reset values
  localparam logic [7:0] ACC_WAIT_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Host APB register map
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_ADDR = 8'h04;
  localparam logic [7:0] APB_WDATA = 8'h08;
  localparam logic [7:0] APB_RDATA = 8'h0c;
  localparam logic [7:0] APB_STATUS = 8'h10;
  localparam int CT_GO = 0;
  localparam int CT_WRITE = 1;
  localparam int CT_HALF = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
endpackage

/* pasi_if.sv */
// AHB spoke between the hub end and the array system interface
`timescale 1ns/1ps
`default_nettype none
interface pasi_if;
  logic hsel;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [pasi_pkg::ADDR_W-1:0] haddr;
  logic [15:0] hwdata;
  logic [15:0] hrdata;
  logic hready;
  logic hresp;
  modport hub (output hsel, htrans, hwrite, hsize, haddr, hwdata,
               input hrdata, hready, hresp);
  modport array (input hsel, htrans, hwrite, hsize, haddr, hwdata,
                 output hrdata, hready, hresp);
endinterface
`default_nettype wire

/* pasi_hub.sv */
// Hub end: APB command registers driving single AHB transfers
`timescale 1ns/1ps
`default_nettype none
module pasi_hub (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // AHB spoke
  pasi_if.hub bus
);
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b100
  } pasi_hstate_e;

  pasi_hstate_e state;
  logic [16:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic [15:0] rd_data;
  logic cmd_write;
  logic cmd_half;
  logic done;

  wire apb_wr = psel && penable && pwrite;
  wire start = apb_wr && paddr == pasi_pkg::APB_CTRL &&
               pwdata[pasi_pkg::CT_GO] && state == PH_IDLE;
  wire busy = state != PH_IDLE;
  wire finish = state == PH_DATA && bus.hready;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // Byte or halfword transfers only
  assign bus.hsel = state == PH_ADDR;
  assign bus.htrans = state == PH_ADDR ? pasi_pkg::HTRANS_NONSEQ : pasi_pkg::HTRANS_IDLE;
  assign bus.hwrite = cmd_write;
  assign bus.hsize = cmd_half ? pasi_pkg::HSIZE_HALF : pasi_pkg::HSIZE_BYTE;
  assign bus.haddr = cmd_addr;
  assign bus.hwdata = cmd_wdata;

  always_comb begin
    case (paddr)
      pasi_pkg::APB_ADDR: prdata = {15'h0000, cmd_addr};
      pasi_pkg::APB_WDATA: prdata = {16'h0000, cmd_wdata};
      pasi_pkg::APB_RDATA: prdata = {16'h0000, rd_data};
      pasi_pkg::APB_STATUS: prdata = {30'h00000000, done, busy};
      pasi_pkg::APB_CTRL: prdata = {29'h00000000, cmd_half, cmd_write, 1'b0};
      default: prdata = 32'h00000000;
    endcase
  end

  // Software orders writes freely; bring-up order is its duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_addr <= 17'h00000;
      cmd_wdata <= 16'h0000;
      cmd_write <= 1'b0;
      cmd_half <= 1'b0;
    end else if (apb_wr && !busy) begin
      if (paddr == pasi_pkg::APB_ADDR) cmd_addr <= pwdata[16:0];
      if (paddr == pasi_pkg::APB_WDATA) cmd_wdata <= pwdata[15:0];
      if (paddr == pasi_pkg::APB_CTRL) begin
        cmd_write <= pwdata[pasi_pkg::CT_WRITE];
        cmd_half <= pwdata[pasi_pkg::CT_HALF];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PH_IDLE;
      rd_data <= 16'h0000;
      done <= 1'b0;
    end else begin
      case (state)
        PH_IDLE: if (start) state <= PH_ADDR;
        PH_ADDR: state <= PH_DATA;
        PH_DATA: if (bus.hready) state <= PH_IDLE;
        default: state <= PH_IDLE;
      endcase
      if (finish && !cmd_write) rd_data <= bus.hrdata;
      // Completion wins over a simultaneous new start
      if (finish) done <= 1'b1;
      else if (start) done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* pasi_array.sv */
// Array end: AHB slave, wait states, clock gating and routing control
`timescale 1ns/1ps
`default_nettype none
module pasi_array #(
  parameter int NUM_BLOCKS = 16
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_wake,
  // AHB spoke
  pasi_if.array bus,
  // Hub spoke selects and power manager
  input wire logic [5:0] spoke_select,
  input wire logic bank_enable,
  // Array side
  input wire logic [7:0] digital_clock_in,
  input wire logic bus_clock_in,
  input wire logic [NUM_BLOCKS-1:0] route_drive_in,
  output logic [7:0] master_dclk_out,
  output logic master_bclk_out,
  output logic [7:0] quad_dclk_out [pasi_pkg::NUM_QUAD],
  output logic [pasi_pkg::NUM_QUAD-1:0] quad_bclk_out,
  output logic [pasi_pkg::NUM_QUAD-1:0] chan_global_write,
  output logic [NUM_BLOCKS-1:0] route_drive_out,
  output logic status_clear_on_read,
  output logic datapath_ram_test,
  output logic bank_global_write,
  output logic [NUM_BLOCKS-1:0] working_reset,
  output logic my_spoke_active
);
  // The quadrant slicing below serves exactly one full bank
  if (NUM_BLOCKS != 16) begin : g_bad_blocks
    $error("Bank holds exactly sixteen blocks");
  end

  typedef enum logic [1:0] {
    PS_IDLE = 2'b01,
    PS_WAIT = 2'b10
  } pasi_sstate_e;

  // Static configuration: reset only by power-on, kept through sleep
  logic [7:0] access_wait_config;
  logic [3:0] bank_global_control;
  logic [7:0] master_digital_clock_gate;
  logic master_bus_clock_gate;
  logic [7:0] quadrant_digital_clock_gate [pasi_pkg::NUM_QUAD];
  logic [2:0] quadrant_bus_clock_gate [pasi_pkg::NUM_QUAD];
  logic [15:0] cfg_mem [256];

  pasi_sstate_e state;
  logic [1:0] wait_cnt;
  logic [16:0] a_addr;
  logic a_write;
  logic a_half;
  logic [15:0] rdata;
  logic [1:0] sleep_sync;

  function automatic logic [1:0] waits_for(input logic [7:0] cfg, input logic page,
                                          input logic wr);
    int pos;
    pos = page == pasi_pkg::PAGE_CFG ? (wr ? pasi_pkg::WT_CFG_WR : pasi_pkg::WT_CFG_RD)
                                     : (wr ? pasi_pkg::WT_WORK_WR : pasi_pkg::WT_WORK_RD);
    return cfg[pos +: 2];
  endfunction

  function automatic logic sys_addr(input logic [16:0] a);
    return a[pasi_pkg::PAGE_BIT] == pasi_pkg::PAGE_CFG &&
           a[15:8] == pasi_pkg::SYS_BASE[15:8];
  endfunction

  function automatic logic work16_addr(input logic [16:0] a);
    return a[pasi_pkg::PAGE_BIT] == pasi_pkg::PAGE_WORK && a[15:0] >= pasi_pkg::WORK16_BASE;
  endfunction

  // Spoke request taken in address phase
  wire req = bus.hsel && bus.htrans == pasi_pkg::HTRANS_NONSEQ && state == PS_IDLE &&
             (bus.hsize == pasi_pkg::HSIZE_BYTE || bus.hsize == pasi_pkg::HSIZE_HALF);
  wire is_sys = sys_addr(a_addr);
  wire [7:0] sys_ofs = a_addr[7:0];
  // Read data is fetched at the address edge so it already stands when hready rises
  wire rd_take = req && !bus.hwrite;
  wire [15:0] r_word = cfg_mem[bus.haddr[8:1]];
  wire r_odd = bus.haddr[0];
  wire r_full = bus.hsize == pasi_pkg::HSIZE_HALF || work16_addr(bus.haddr);
  logic [7:0] r_sys;
  wire complete = state == PS_WAIT && wait_cnt == 2'h0;
  wire do_wr = complete && a_write;
  wire [15:0] wmask = a_half ? 16'hffff : (a_addr[0] ? 16'hff00 : 16'h00ff);
  wire [15:0] wval = bus.hwdata & wmask;
  wire [7:0] wbyte = a_addr[0] && !a_half ? bus.hwdata[15:8] : bus.hwdata[7:0];
  wire route_en = bank_global_control[pasi_pkg::BC_ROUTE_EN];

  // Wait states then OKAY completion
  assign bus.hready = state == PS_IDLE || complete;
  assign bus.hresp = pasi_pkg::HRESP_OKAY;
  assign bus.hrdata = rdata;
  assign my_spoke_active = spoke_select[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PS_IDLE;
      wait_cnt <= 2'h0;
      a_addr <= 17'h00000;
      a_write <= 1'b0;
      a_half <= 1'b0;
    end else begin
      case (state)
        PS_IDLE: if (req) begin
          state <= PS_WAIT;
          a_addr <= bus.haddr;
          a_write <= bus.hwrite;
          a_half <= bus.hsize == pasi_pkg::HSIZE_HALF;
          wait_cnt <= waits_for(access_wait_config, bus.haddr[pasi_pkg::PAGE_BIT],
                                bus.hwrite);
        end
        PS_WAIT: if (wait_cnt == 2'h0) state <= PS_IDLE;
                 else wait_cnt <= wait_cnt - 2'h1;
        default: state <= PS_IDLE;
      endcase
    end
  end

  // Configuration writes in any order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_wait_config <= pasi_pkg::ACC_WAIT_RST;
      bank_global_control <= 4'h0;
      master_digital_clock_gate <= pasi_pkg::ZERO8;
      master_bus_clock_gate <= 1'b0;
      for (int q = 0; q < pasi_pkg::NUM_QUAD; q++) begin
        quadrant_digital_clock_gate[q] <= pasi_pkg::ZERO8;
        quadrant_bus_clock_gate[q] <= 3'h0;
      end
    end else if (do_wr && is_sys) begin
      case (sys_ofs)
        pasi_pkg::OFS_ACC_WAIT: access_wait_config <= wbyte;
        pasi_pkg::OFS_BANK_GLOB: bank_global_control <= wbyte[3:0];
        pasi_pkg::OFS_MDCLK: master_digital_clock_gate <= wbyte;
        pasi_pkg::OFS_MBCLK: master_bus_clock_gate <= wbyte[0];
        default: begin
          for (int q = 0; q < pasi_pkg::NUM_QUAD; q++) begin
            if (sys_ofs == pasi_pkg::OFS_QDCLK0 + 8'(q))
              quadrant_digital_clock_gate[q] <= wbyte;
            if (sys_ofs == pasi_pkg::OFS_QBCLK0 + 8'(q))
              quadrant_bus_clock_gate[q] <= wbyte[2:0];
          end
        end
      endcase
    end
  end

  // Block configuration and working storage model
  always_ff @(posedge pclk) begin
    if (do_wr && !is_sys)
      cfg_mem[a_addr[8:1]] <= (cfg_mem[a_addr[8:1]] & ~wmask) | wval;
  end

  always_comb begin
    case (bus.haddr[7:0])
      pasi_pkg::OFS_ACC_WAIT: r_sys = access_wait_config;
      pasi_pkg::OFS_BANK_GLOB: r_sys = {4'h0, bank_global_control};
      pasi_pkg::OFS_MDCLK: r_sys = master_digital_clock_gate;
      pasi_pkg::OFS_MBCLK: r_sys = {7'h00, master_bus_clock_gate};
      default: r_sys = pasi_pkg::ZERO8;
    endcase
  end

  // Byte reads land in the lane picked by the low address bit, except in the 16-bit working region, which returns the whole word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 16'h0000;
    end else if (rd_take) begin
      if (sys_addr(bus.haddr)) rdata <= r_odd ? {r_sys, 8'h00} : {8'h00, r_sys};
      else if (r_full) rdata <= r_word;
      else rdata <= r_odd ? {r_word[15:8], 8'h00} : {8'h00, r_word[7:0]};
    end
  end

  // Sleep wake resets working registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sleep_sync <= 2'h0;
    else sleep_sync <= {sleep_sync[0], sleep_wake};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) working_reset <= '1;
    else working_reset <= {NUM_BLOCKS{sleep_sync[1]}};
  end

  // Bank control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_clear_on_read <= 1'b1;
      datapath_ram_test <= 1'b0;
      bank_global_write <= 1'b0;
    end else begin
      status_clear_on_read <= !bank_global_control[pasi_pkg::BC_NO_CLR_RD];
      datapath_ram_test <= bank_global_control[pasi_pkg::BC_RAM_TEST];
      bank_global_write <= bank_global_control[pasi_pkg::BC_GLOB_WR];
    end
  end

  // Two-level clock gating; clocks need bank enable too
  // Gating here is a logic AND model; a real tree uses latch-based cells
  assign master_dclk_out = digital_clock_in & master_digital_clock_gate &
                           {8{bank_enable}};
  assign master_bclk_out = bus_clock_in && master_bus_clock_gate && bank_enable;

  genvar g;
  generate
    for (g = 0; g < pasi_pkg::NUM_QUAD; g++) begin : gq
      wire quad_route_ok = route_en && !quadrant_bus_clock_gate[g][pasi_pkg::QB_ROUTE_DIS];
      assign quad_dclk_out[g] = master_dclk_out & quadrant_digital_clock_gate[g];
      assign quad_bclk_out[g] = master_bclk_out &&
                                quadrant_bus_clock_gate[g][pasi_pkg::QB_BUS_EN];
      assign chan_global_write[g] = quadrant_bus_clock_gate[g][pasi_pkg::QB_CHAN_GWR];
      // Floating routes held low until routing is enabled
      assign route_drive_out[g*4 +: 4] = route_drive_in[g*4 +: 4] & {4{quad_route_ok}};
    end
  endgenerate
endmodule
`default_nettype wire

/* pasi_chk.sv */
// Protocol checker for the AHB spoke between hub and array
`timescale 1ns/1ps
`default_nettype none
module pasi_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // AHB spoke
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [pasi_pkg::ADDR_W-1:0] haddr,
  input wire logic [15:0] hwdata,
  input wire logic [15:0] hrdata,
  input wire logic hready,
  input wire logic hresp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire size_ok = hsize == pasi_pkg::HSIZE_BYTE || hsize == pasi_pkg::HSIZE_HALF;
  wire nonseq = hsel && htrans == pasi_pkg::HTRANS_NONSEQ;
  wire take = nonseq && hready && size_ok;
  a_resp_okay: assert property (hresp == pasi_pkg::HRESP_OKAY)
    else $error("response not okay");
  a_trans_legal: assert property (htrans == pasi_pkg::HTRANS_IDLE || !hsel || nonseq)
    else $error("illegal transfer type");
  a_size_legal: assert property (nonseq |-> size_ok)
    else $error("transfer size not byte or halfword");
  a_req_hold: assert property (!hready |-> $stable(haddr) && $stable(hwdata) && $stable(hwrite))
    else $error("request changed during wait");
  a_idle_ready: assert property (hready && !take |=> hready)
    else $error("ready dropped without a transfer");
  a_wait_bound: assert property (take |=> ##[0:3] hready)
    else $error("transfer not completed within wait limit");
  a_wait_end: assert property ($fell(hready) |-> ##[1:3] hready)
    else $error("wait state run too long");
  a_no_pipe: assert property (take |=> !nonseq)
    else $error("second transfer before completion");
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench driving the hub over APB against the array end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, sleep_wake = 0, bank_enable = 0, bus_clock_in = 1;
  logic [5:0] spoke_select = 0;
  logic [7:0] digital_clock_in = 8'hff, master_dclk_out, q8;
  logic [7:0] quad_dclk_out [pasi_pkg::NUM_QUAD];
  logic [15:0] route_drive_in = 16'hffff, route_drive_out, working_reset, q16;
  logic [3:0] quad_bclk_out, chan_global_write;
  logic master_bclk_out, status_clear_on_read, datapath_ram_test, bank_global_write;
  logic my_spoke_active;
  int error_cnt = 0, checks_done = 0, lowcnt = 0, lowtot = 0;
  always #10 pclk = ~pclk;
  pasi_if ifc ();
  pasi_hub i_pasi_hub (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus(ifc));
  pasi_array i_pasi_array (.pclk, .presetn, .sleep_wake, .bus(ifc), .spoke_select, .bank_enable,
    .digital_clock_in, .bus_clock_in, .route_drive_in, .master_dclk_out, .master_bclk_out,
    .quad_dclk_out, .quad_bclk_out, .chan_global_write, .route_drive_out, .status_clear_on_read,
    .datapath_ram_test, .bank_global_write, .working_reset, .my_spoke_active);
  pasi_chk i_pasi_chk (.pclk, .presetn, .hsel(ifc.hsel), .htrans(ifc.htrans),
    .hwrite(ifc.hwrite), .hsize(ifc.hsize), .haddr(ifc.haddr), .hwdata(ifc.hwdata),
    .hrdata(ifc.hrdata), .hready(ifc.hready), .hresp(ifc.hresp));
  // Wait cycles seen on the spoke since the start of the run
  always @(posedge pclk) if (ifc.hready === 1'b0) lowtot <= lowtot + 1;
  task summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task tmo(input string n);
    error_cnt++;
    $display("ERROR %s expected completion seen timeout", n);
    summarize;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Starts one edge late so a release and the next setup never share a time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) tmo("pready");
    q = prdata;
    chk("pslverr", 0, pslverr);
    psel <= 0; penable <= 0;
  endtask
  task op(input logic w, input logic h, input logic [16:0] a, input logic [15:0] d,
          output logic [15:0] q);
    logic [31:0] r;
    int i;
    int base;
    apb(1, pasi_pkg::APB_ADDR, {15'h0, a}, r);
    apb(1, pasi_pkg::APB_WDATA, {16'h0, d}, r);
    base = lowtot;
    apb(1, pasi_pkg::APB_CTRL, {29'h0, h, w, 1'b1}, r);
    for (i = 0; i < 40; i++) begin
      apb(0, pasi_pkg::APB_STATUS, 0, r);
      if (r[pasi_pkg::ST_DONE] === 1'b1) break;
    end
    if (i == 40) tmo("spoke done");
    apb(0, pasi_pkg::APB_RDATA, 0, r);
    q = r[15:0];
    lowcnt = lowtot - base;
  endtask
  function automatic logic [16:0] ra(input logic [7:0] o);
    ra = {pasi_pkg::PAGE_CFG, pasi_pkg::SYS_BASE | {8'h00, o}};
  endfunction
  task rw(input logic [7:0] o, input logic [7:0] d);
    op(1, 0, ra(o), {d, d}, q16);
  endtask
  task rd(input logic h, input logic [16:0] a, output logic [15:0] q);
    op(0, h, a, 16'h0000, q);
  endtask
  task rr(input logic [7:0] o, output logic [7:0] q);
    rd(0, ra(o), q16);
    q = o[0] ? q16[15:8] : q16[7:0];
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    chk("working_reset", 16'hffff, working_reset);
    chk("clear_on_read", 1, status_clear_on_read);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    bank_enable <= 1;
    repeat (2) @(posedge pclk);
    chk("working_reset", 0, working_reset);
    chk("master_dclk", 0, master_dclk_out);
    chk("master_bclk", 0, master_bclk_out);
    chk("quad_dclk0", 0, quad_dclk_out[0]);
    chk("route_out", 0, route_drive_out);
    rr(pasi_pkg::OFS_ACC_WAIT, q8);
    chk("acc_wait", pasi_pkg::ACC_WAIT_RST, q8);
    rw(pasi_pkg::OFS_ACC_WAIT, 8'he4);
    rr(pasi_pkg::OFS_ACC_WAIT, q8);
    chk("acc_wait", 8'he4, q8);
    chk("cfg read waits", 2, lowcnt);
    rw(pasi_pkg::OFS_BANK_GLOB, 8'h0e);
    chk("cfg write waits", 3, lowcnt);
    repeat (2) @(posedge pclk);
    chk("clear_on_read", 0, status_clear_on_read);
    chk("datapath_ram_test", 1, datapath_ram_test);
    chk("bank_gwr", 1, bank_global_write);
    chk("route_out", 0, route_drive_out);
    bank_enable <= 0;
    rw(pasi_pkg::OFS_MDCLK, 8'ha5);
    rw(pasi_pkg::OFS_MBCLK, 8'h01);
    chk("master_dclk", 0, master_dclk_out);
    bank_enable <= 1;
    repeat (2) @(posedge pclk);
    chk("master_dclk", 8'ha5, master_dclk_out);
    chk("master_bclk", 1, master_bclk_out);
    rw(pasi_pkg::OFS_QDCLK0 + 8'h01, 8'h0f);
    rw(pasi_pkg::OFS_QBCLK0 + 8'h02, 8'h03);
    chk("quad_dclk1", 8'h05, quad_dclk_out[1]);
    chk("quad_dclk0", 0, quad_dclk_out[0]);
    chk("quad_bclk", 4'h4, quad_bclk_out);
    chk("chan_gwr", 4'h4, chan_global_write);
    rw(pasi_pkg::OFS_QBCLK0 + 8'h01, 8'h04);
    rw(pasi_pkg::OFS_BANK_GLOB, 8'h0f);
    chk("route_out", 16'hff0f, route_drive_out);
    rr(pasi_pkg::OFS_BANK_GLOB, q8);
    chk("bank_global_control", 8'h0f, q8);
    rw(pasi_pkg::OFS_QBCLK0 + 8'h01, 8'h00);
    chk("route_out", 16'hffff, route_drive_out);
    op(1, 1, 17'h01002, 16'h1234, q16);
    chk("work write waits", 1, lowcnt);
    op(1, 0, 17'h01003, 16'h5a5a, q16);
    rd(1, 17'h01002, q16);
    chk("work half", 16'h5a34, q16);
    chk("work read waits", 0, lowcnt);
    spoke_select <= 6'h01;
    @(posedge pclk);
    @(posedge pclk);
    chk("spoke_active", 1, my_spoke_active);
    spoke_select <= 6'h3e;
    @(posedge pclk);
    @(posedge pclk);
    chk("spoke_active", 0, my_spoke_active);
    sleep_wake <= 1;
    repeat (5) @(posedge pclk);
    chk("working_reset", 16'hffff, working_reset);
    sleep_wake <= 0;
    repeat (5) @(posedge pclk);
    chk("working_reset", 0, working_reset);
    rr(pasi_pkg::OFS_MDCLK, q8);
    chk("mdclk kept", 8'ha5, q8);
    summarize;
  end
endmodule
`default_nettype wire
